// ==== rtl/aah_pkg.sv ====
/*
  constants, codes and types for the addressing, alert and hold register bank.
  assumes one 25 MHz clock and a byte-wide command stream from a uart.
*/
package aah_pkg;
  // command framing
  localparam logic [7:0] HDR_BYTE  = 8'hff;
  localparam logic [7:0] SIZE_BYTE = 8'h02;
  localparam logic [7:0] ESC_BYTE  = 8'hfe;
  localparam logic [7:0] ACK_BYTE  = 8'h06;

  // register slots: 0..3 user mask byte3..0, 4..7 target serial byte3..0
  localparam int NREG      = 10;
  localparam int IDX_UM3   = 0;
  localparam int IDX_UM2   = 1;
  localparam int IDX_UM1   = 2;
  localparam int IDX_UM0   = 3;
  localparam int IDX_TS3   = 4;
  localparam int IDX_TS2   = 5;
  localparam int IDX_TS1   = 6;
  localparam int IDX_TS0   = 7;
  localparam int IDX_ALERT = 8;
  localparam int IDX_HOLD  = 9;
  localparam logic [NREG-1:0][7:0] VOL_ADDR = {8'h6e, 8'h6c, 8'h6b, 8'h6a, 8'h69,
                                               8'h68, 8'h65, 8'h64, 8'h63, 8'h62};
  localparam logic [NREG-1:0][7:0] NV_ADDR  = {8'h23, 8'h21, 8'h20, 8'h1f, 8'h1e,
                                               8'h1d, 8'h1a, 8'h19, 8'h18, 8'h17};
  localparam logic [NREG-1:0][7:0] NV_RESET = {NREG{8'h00}};
  localparam logic [7:0] FAULT_CODE_ADDR = 8'h7e;
  localparam logic [7:0] UNMAPPED_VAL    = 8'h00;

  // receive hold settings
  localparam logic [7:0] HOLD_ON = 8'h01;

  // fault codes, group bit is 0x08, 0x10, 0x20 or 0x40
  localparam int NFAULT = 8;
  localparam int EV_HOST_OVF  = 0;
  localparam int EV_RADIO_OVF = 1;
  localparam int EV_WR_FAIL   = 2;
  localparam int EV_NO_ACK    = 3;
  localparam int EV_BAD_SUM   = 4;
  localparam int EV_BAD_HDR   = 5;
  localparam int EV_BAD_SEQ   = 6;
  localparam int EV_BAD_KIND  = 7;
  localparam logic [NFAULT-1:0][7:0] FAULT_CODES = {8'h43, 8'h42, 8'h41, 8'h40,
                                                    8'h20, 8'h10, 8'h09, 8'h08};

  // radio buffer
  localparam int RXBUF_AW    = 6;
  localparam int RXBUF_DEPTH = 64;

  typedef enum logic [2:0] {PS_IDLE, PS_SIZE, PS_THIRD, PS_RADDR, PS_WVAL} aah_parse_e;
  typedef enum logic [1:0] {RS_NONE, RS_ACK, RS_ADDR, RS_VAL} aah_rsp_e;
endpackage

// ==== rtl/aah_sync2.sv ====
/*
  two flip-flop synchroniser for one level from a pin.
  assumes the level may change at any time relative to clock.
*/
`timescale 1ns/10ps
module aah_sync2
  import aah_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // level
  input  wire logic din,
  output wire logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } aah_sync_s;

  aah_sync_s s_ff;
  aah_sync_s nxt_s;

  always_comb
  begin
    nxt_s.meta   = din;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= {RST_VAL, RST_VAL};
    else
      s_ff <= nxt_s;
  end

  assign dout = s_ff.stable;
endmodule

// ==== rtl/aah_byte_ram.sv ====
/*
  small byte memory with one write port and a registered read port.
  assumes the caller never reads and writes one slot in the same cycle.
*/
`timescale 1ns/10ps
module aah_byte_ram
  import aah_pkg::*;
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // write side
  input  wire logic                wr_en,
  input  wire logic [RXBUF_AW-1:0] wr_addr,
  input  wire logic [7:0]          wr_data,
  // read side, data one cycle after rd_en
  input  wire logic                rd_en,
  input  wire logic [RXBUF_AW-1:0] rd_addr,
  output wire logic [7:0]          rd_data
);
  typedef struct packed {
    logic [RXBUF_DEPTH-1:0][7:0] mem;
    logic [7:0]                  rd;
  } aah_ram_s;

  aah_ram_s s_ff;
  aah_ram_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (wr_en)
      nxt_s.mem[wr_addr] = wr_data;
    if (rd_en)
      nxt_s.rd = s_ff.mem[rd_addr];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign rd_data = s_ff.rd;
endmodule

// ==== rtl/aah_regbank.sv ====
/*
  register bank for user id mask, target serial number, alert mask and
  receive hold, with the framed command parser, fault recording and the
  radio receive buffer that feeds the serial output.
  assumes a uart on the same clock delivers and takes command bytes, and
  that host_cmd_n is a raw pin.
*/
// Operation
// [R1] four user id mask bytes, volatile 0x62-0x65, stored 0x17-0x1a
// [R2] extended mask uses all four bytes; short mask uses bytes one and zero
// [R3] every mask and serial byte is read and written on its own
// [R4] four target serial bytes, volatile 0x68-0x6b, stored 0x1d-0x20
// [R5] target serial: most significant byte at lowest address
// [R6] on a fault, and its code with the alert mask
// [R7] nonzero masked code drives the host alert line high
// [R8] reading the fault code register clears it and drops the alert line
// [R9] zero masked code leaves alert low but still records the code
// [R10] mask 0x08 covers buffer overflows, 0x10 register write failure
// [R11] mask 0x20 missing radio ack, 0x40 the four receive errors
// [R12] mask 0xff lets every fault alert; bits combine as a union
// [R13] read: ff 02 fe addr, answered by 06, addr, value
// [R14] write: ff 02 addr value, with no escape byte
// [R15] hold at 0x01 buffers radio bytes while host command line is low
// [R16] command line high again releases all buffered radio bytes
// [R17] hold at 0x00 sends radio bytes at once with response flag high
// [R18] packet receive option set overrides the hold setting
// [R19] alert mask at 0x6c/0x21, receive hold at 0x6e/0x23
// [R20] after reset the volatile copies load from the stored copies; reset clears the stored copies first, so the load brings NV_RESET
`timescale 1ns/10ps
module aah_regbank
  import aah_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // command bytes from the uart
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_valid,
  output wire logic        cmd_ready,
  // bytes to the uart
  output wire logic [7:0]  out_byte,
  output wire logic        out_valid,
  input  wire logic        out_ready,
  output wire logic        response_flag_line,
  // radio receive bytes
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  // pins and neighbouring control
  input  wire logic        host_cmd_n,
  input  wire logic        packet_receive_option,
  output wire logic        host_alert_line,
  // fault events, one-cycle pulses
  input  wire logic        host_buffer_overflow,
  input  wire logic        missing_radio_ack,
  input  wire logic        bad_checksum,
  input  wire logic        bad_frame_header,
  input  wire logic        bad_sequence_number,
  input  wire logic        bad_frame_kind,
  // active configuration
  output wire logic [31:0] user_id_filter_mask,
  output wire logic [15:0] user_id_short_mask,
  output wire logic [31:0] target_serial_number
);
  typedef struct packed {
    logic                       loading;
    aah_parse_e                 pst;
    aah_rsp_e                   rsp;
    logic [7:0]                 addr;
    logic [NREG-1:0][7:0]       vol;
    logic [NREG-1:0][7:0]       nv;
    logic [7:0]                 fault_code;
    logic                       alert;
    logic [RXBUF_AW-1:0]        wptr;
    logic [RXBUF_AW-1:0]        rptr;
    logic [RXBUF_AW:0]          count;
    logic                       rd_pend;
    logic [7:0]                 out_byte;
    logic                       out_valid;
    logic                       out_flag;
  } aah_bank_s;

  aah_bank_s           s_ff;
  aah_bank_s           nxt_s;
  logic                cmd_line_n_s;
  logic [7:0]          ram_rdata;
  logic                ram_we;
  logic                ram_re;
  logic                cmd_fire;
  logic                rx_fire;
  logic                rx_full;
  logic                hold_active;
  logic                slot_free;
  logic                vhit;
  logic                nhit;
  logic                fhit;
  logic [3:0]          vidx;
  logic [3:0]          nidx;
  logic [7:0]          rd_val;
  logic                wr_fail;
  logic [NFAULT-1:0]   ev;
  logic                ev_any;
  logic [7:0]          ev_code;
  logic                pop;

  // raw pin, two stages before any use; idles high
  aah_sync2 #(
    .RST_VAL (1'b1)
  ) u_cmd_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (host_cmd_n),
    .dout  (cmd_line_n_s)
  );

  aah_byte_ram u_rxbuf (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (ram_we),
    .wr_addr (s_ff.wptr),
    .wr_data (rx_byte),
    .rd_en   (ram_re),
    .rd_addr (s_ff.rptr),
    .rd_data (ram_rdata)
  );

  // commands are refused while an answer is pending or the load runs
  assign cmd_ready = (s_ff.rsp == RS_NONE) && !s_ff.loading;
  assign cmd_fire  = cmd_valid && cmd_ready;
  assign rx_full   = (s_ff.count == (RXBUF_AW+1)'(RXBUF_DEPTH));
  // radio traffic cannot be stalled, so a full buffer drops the byte
  assign rx_fire   = rx_valid && !rx_full;
  assign ram_we    = rx_fire;
  assign slot_free = !s_ff.out_valid || out_ready;
  assign hold_active = (s_ff.vol[IDX_HOLD] == HOLD_ON)        // [R15]
                       && !packet_receive_option              // [R18]
                       && !cmd_line_n_s;

  // address decode of the latched address
  always_comb
  begin
    vhit = 1'b0;
    nhit = 1'b0;
    vidx = '0;
    nidx = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (s_ff.addr == VOL_ADDR[i])                           // [R1] [R4] [R19]
      begin
        vhit = 1'b1;
        vidx = 4'(i);
      end
      if (s_ff.addr == NV_ADDR[i])
      begin
        nhit = 1'b1;
        nidx = 4'(i);
      end
    end
    fhit = (s_ff.addr == FAULT_CODE_ADDR);
    if (vhit)
      rd_val = s_ff.vol[vidx];                                // [R3]
    else if (nhit)
      rd_val = s_ff.nv[nidx];
    else if (fhit)
      rd_val = s_ff.fault_code;
    else
      rd_val = UNMAPPED_VAL;
  end

  // fault sources; lowest index wins when several coincide
  always_comb
  begin
    ev = '0;
    ev[EV_HOST_OVF]  = host_buffer_overflow;
    ev[EV_RADIO_OVF] = rx_valid && rx_full;
    ev[EV_WR_FAIL]   = wr_fail;
    ev[EV_NO_ACK]    = missing_radio_ack;
    ev[EV_BAD_SUM]   = bad_checksum;
    ev[EV_BAD_HDR]   = bad_frame_header;
    ev[EV_BAD_SEQ]   = bad_sequence_number;
    ev[EV_BAD_KIND]  = bad_frame_kind;
    ev_any  = |ev;
    ev_code = '0;
    for (int i = NFAULT - 1; i >= 0; i--)
    begin
      if (ev[i])
        ev_code = FAULT_CODES[i];                             // [R10] [R11]
    end
  end

  always_comb
  begin
    nxt_s   = s_ff;
    wr_fail = 1'b0;
    ram_re  = 1'b0;
    pop     = 1'b0;

    if (s_ff.loading)
    begin
      nxt_s.vol     = s_ff.nv;                                // [R20]
      nxt_s.loading = 1'b0;
    end

    // command parser
    if (cmd_fire)
    begin
      case (s_ff.pst)
        PS_IDLE:
        begin
          if (cmd_byte == HDR_BYTE)
            nxt_s.pst = PS_SIZE;
        end
        PS_SIZE:
        begin
          if (cmd_byte == SIZE_BYTE)
            nxt_s.pst = PS_THIRD;
          else if (cmd_byte != HDR_BYTE)
            nxt_s.pst = PS_IDLE;
        end
        PS_THIRD:
        begin
          if (cmd_byte == ESC_BYTE)
            nxt_s.pst = PS_RADDR;                             // [R13]
          else
          begin
            nxt_s.addr = cmd_byte;                            // [R14]
            nxt_s.pst  = PS_WVAL;
          end
        end
        PS_RADDR:
        begin
          nxt_s.addr = cmd_byte;
          nxt_s.rsp  = RS_ACK;
          nxt_s.pst  = PS_IDLE;
        end
        PS_WVAL:
        begin
          // stored copies never become active: reset clears them before the load
          if (vhit)
            nxt_s.vol[vidx] = cmd_byte;                       // [R3]
          else if (nhit)
            nxt_s.nv[nidx] = cmd_byte;
          else
            wr_fail = 1'b1;
          nxt_s.pst = PS_IDLE;
        end
        default:
          nxt_s.pst = PS_IDLE;
      endcase
    end

    // output slot
    if (slot_free)
      nxt_s.out_valid = 1'b0;
    if (s_ff.rd_pend)
    begin
      nxt_s.out_byte  = ram_rdata;
      nxt_s.out_flag  = 1'b1;                                 // [R17]
      nxt_s.out_valid = 1'b1;
      nxt_s.rd_pend   = 1'b0;
    end
    else if (slot_free && s_ff.rsp != RS_NONE)
    begin
      nxt_s.out_valid = 1'b1;
      nxt_s.out_flag  = 1'b0;
      case (s_ff.rsp)
        RS_ACK:
        begin
          nxt_s.out_byte = ACK_BYTE;                          // [R13]
          nxt_s.rsp      = RS_ADDR;
        end
        RS_ADDR:
        begin
          nxt_s.out_byte = s_ff.addr;
          nxt_s.rsp      = RS_VAL;
        end
        RS_VAL:
        begin
          nxt_s.out_byte = rd_val;
          nxt_s.rsp      = RS_NONE;
          if (fhit)
          begin
            nxt_s.fault_code = '0;                            // [R8]
            nxt_s.alert      = 1'b0;
          end
        end
        default:
          nxt_s.rsp = RS_NONE;
      endcase
    end
    else if (slot_free && s_ff.count != '0 && !hold_active)
    begin
      // held bytes drain once the line rises
      ram_re        = 1'b1;                                   // [R16]
      pop           = 1'b1;
      nxt_s.rptr    = s_ff.rptr + 1'b1;
      nxt_s.rd_pend = 1'b1;
    end

    // radio buffer occupancy
    if (rx_fire)
      nxt_s.wptr = s_ff.wptr + 1'b1;                          // [R15]
    nxt_s.count = s_ff.count + (RXBUF_AW+1)'(rx_fire) - (RXBUF_AW+1)'(pop);

    // recording after the clear so a new fault wins
    if (ev_any)
    begin
      nxt_s.fault_code = ev_code;                             // [R9]
      if ((ev_code & s_ff.vol[IDX_ALERT]) != 8'h00)           // [R6] [R12]
        nxt_s.alert = 1'b1;                                   // [R7]
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_ff         <= '0;
      s_ff.loading <= 1'b1;
      s_ff.pst     <= PS_IDLE;
      s_ff.rsp     <= RS_NONE;
      s_ff.nv      <= NV_RESET;
    end
    else
      s_ff <= nxt_s;
  end

  assign out_byte           = s_ff.out_byte;
  assign out_valid          = s_ff.out_valid;
  assign response_flag_line = s_ff.out_flag;
  assign host_alert_line    = s_ff.alert;
  assign user_id_filter_mask  = {s_ff.vol[IDX_UM3], s_ff.vol[IDX_UM2],
                                 s_ff.vol[IDX_UM1], s_ff.vol[IDX_UM0]};  // [R2]
  assign user_id_short_mask   = {s_ff.vol[IDX_UM1], s_ff.vol[IDX_UM0]};  // [R2]
  assign target_serial_number = {s_ff.vol[IDX_TS3], s_ff.vol[IDX_TS2],
                                 s_ff.vol[IDX_TS1], s_ff.vol[IDX_TS0]};  // [R5]
endmodule

// ==== verification/aah_regbank_props.sv ====
/*
  concurrent checks on the register bank ports.
  assumes it is bound to aah_regbank and sees only its ports.
*/
`timescale 1ns/10ps
module aah_regbank_props
  import aah_pkg::*;
(
  // clock, reset and command side
  input wire logic        clock, rst_n, cmd_valid, cmd_ready, out_valid, out_ready,
  input wire logic        response_flag_line, rx_valid, host_cmd_n, packet_receive_option,
  input wire logic [7:0]  cmd_byte, out_byte, rx_byte,
  // alerts and faults
  input wire logic        host_alert_line, host_buffer_overflow, missing_radio_ack,
  input wire logic        bad_checksum, bad_frame_header, bad_sequence_number, bad_frame_kind,
  // configuration
  input wire logic [31:0] user_id_filter_mask, target_serial_number,
  input wire logic [15:0] user_id_short_mask
);
  logic [1:0] up_ff;
  logic [6:0] pend_ff;
  wire        fault_in = host_buffer_overflow | missing_radio_ack | bad_checksum |
                         bad_frame_header | bad_sequence_number | bad_frame_kind;

  // the load after reset changes the configuration, so wait two edges
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      up_ff   <= 2'h0;
      pend_ff <= 7'h00;
    end
    else
    begin
      up_ff   <= {up_ff[0], 1'b1};
      pend_ff <= pend_ff + 7'((rx_valid && pend_ff < 7'h41) ? 1 : 0)
                 - 7'((out_valid && out_ready && response_flag_line) ? 1 : 0);
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_short_mask: assert property (user_id_short_mask == user_id_filter_mask[15:0])
    else $error("short mask differs from low half of user mask");
  chk_alert_cause: assert property ($rose(host_alert_line) |-> $past(fault_in || rx_valid || cmd_valid)
    || $past(rx_valid, 2) || $past(cmd_valid, 2))
    else $error("alert rose without a fault");
  chk_alert_keep: assert property (host_alert_line && cmd_ready |=> host_alert_line)
    else $error("alert dropped without a read");
  chk_alert_clear: assert property ($fell(host_alert_line) |-> out_valid && !response_flag_line)
    else $error("alert dropped outside a read answer");
  chk_ack_first: assert property ($rose(out_valid) && !response_flag_line |-> out_byte == ACK_BYTE)
    else $error("read answer does not open with ack");
  chk_out_stand: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte)
    && $stable(response_flag_line))
    else $error("output byte changed while stalled");
  chk_cfg_by_cmd: assert property (disable iff (!rst_n || !up_ff[1])
    $changed({user_id_filter_mask, target_serial_number}) |-> $past(cmd_valid && cmd_ready))
    else $error("configuration changed without a command byte");
  chk_radio_source: assert property (out_valid && response_flag_line |-> pend_ff != 7'h00)
    else $error("radio byte shown with none received");
endmodule

bind aah_regbank aah_regbank_props i_aah_regbank_props (.*);

// ==== verification/aah_host_model.sv ====
/*
  host processor model: sends framed commands, collects answers and radio bytes.
  assumes the bank's command port handshake and a shared clock.
*/
`timescale 1ns/10ps
module aah_host_model
  import aah_pkg::*;
(
  input  wire logic       clock,
  output logic      [7:0] cmd_byte,
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_valid,
  output wire logic       out_ready,
  input  wire logic       response_flag_line
);
  logic [7:0] rsp_q[$];
  logic [7:0] radio_q[$];
  logic       stall = 1'b0;

  initial
  begin
    cmd_byte  = 8'h00;
    cmd_valid = 1'b0;
  end
  assign out_ready = !stall;

  always @(posedge clock)
    if (out_valid && out_ready)
      if (response_flag_line)
        radio_q.push_back(out_byte);
      else
        rsp_q.push_back(out_byte);

  // byte held until an edge sees ready
  task automatic put(input logic [7:0] b);
    cmd_byte  = b;
    cmd_valid = 1'b1;
    while (!cmd_ready)
      @(posedge clock) #1;
    @(posedge clock) #1;
  endtask

  // read is ff 02 fe addr, write ff 02 addr value
  task automatic frame(input logic [7:0] b2, input logic [7:0] b3);
    put(HDR_BYTE);
    put(SIZE_BYTE);
    put(b2);
    put(b3);
    cmd_valid = 1'b0;
    cmd_byte  = ~b3; // released bus shows no stale value
    // one idle edge so the next frame never re-raises valid in this step
    @(posedge clock) #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] r);
    int n;
    rsp_q.delete();
    frame(ESC_BYTE, a);
    n = 0;
    while (rsp_q.size() < 3 && n < 100)
    begin
      @(posedge clock) #1;
      n++;
    end
    r = (rsp_q.size() >= 3) ? {rsp_q[0], rsp_q[1], rsp_q[2]} : 24'hxxxxxx;
  endtask
endmodule

// ==== verification/tb_top.sv ====
/*
  self-checking bench for the register bank.
  assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module tb_top;
  import aah_pkg::*;
  logic        clock, rst_n, cmd_valid, cmd_ready, out_valid, out_ready, response_flag_line;
  logic        rx_valid, host_cmd_n, packet_receive_option, host_alert_line;
  logic [7:0]  cmd_byte, out_byte, rx_byte;
  logic [5:0]  flt;
  logic [31:0] user_id_filter_mask, target_serial_number;
  logic [15:0] user_id_short_mask;
  logic [23:0] r;
  int          fails, n_compared;

  aah_regbank i_aah_regbank (.*, .host_buffer_overflow(flt[0]), .missing_radio_ack(flt[1]),
    .bad_checksum(flt[2]), .bad_frame_header(flt[3]), .bad_sequence_number(flt[4]), .bad_frame_kind(flt[5]));
  aah_host_model i_aah_host_model (.*);

  always #20 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic print_verdict;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clock) #1;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    i_aah_host_model.rd(a, r);
    chk(what, {8'h00, ACK_BYTE, a, exp}, {8'h00, r});
  endtask

  task automatic rx_send(input logic [7:0] b);
    i_aah_host_model.radio_q.delete();
    for (int i = 0; i < 3; i++)
    begin
      rx_byte  = b + 8'(i);
      rx_valid = 1'b1;
      @(posedge clock) #1;
    end
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask

  task automatic rx_expect(input string what, input logic [7:0] b);
    int n;
    n = 0;
    while (i_aah_host_model.radio_q.size() < 3 && n < 200)
    begin
      @(posedge clock) #1;
      n++;
    end
    chk(what, {8'h00, b, b + 8'h01, b + 8'h02}, {8'h00, i_aah_host_model.radio_q[0],
        i_aah_host_model.radio_q[1], i_aah_host_model.radio_q[2]});
  endtask

  task automatic t_defaults;
    for (int i = 0; i < NREG; i++)
    begin
      rd_chk("volatile slot", VOL_ADDR[i], 8'h00);
      rd_chk("stored slot", NV_ADDR[i], 8'h00);
    end
    rd_chk("unmapped slot", 8'h30, UNMAPPED_VAL);
  endtask

  task automatic t_bytes;
    for (int i = 0; i < 8; i++)
      i_aah_host_model.frame(VOL_ADDR[i], 8'(8'h11 * (i + 1)));
    chk("user mask", 32'h11223344, user_id_filter_mask);
    chk("short mask", 32'h00003344, {16'h0000, user_id_short_mask});
    chk("target serial", 32'h55667788, target_serial_number);
    rd_chk("serial byte", 8'h6a, 8'h77);
  endtask

  // every fault group against every listed mask
  task automatic t_alert;
    logic [7:0] masks[7] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'hff, 8'h00};
    logic [7:0] codes[7] = '{8'h08, 8'h20, 8'h40, 8'h41, 8'h42, 8'h43, 8'h10};
    for (int m = 0; m < 7; m++)
    begin
      i_aah_host_model.frame(VOL_ADDR[IDX_ALERT], masks[m]);
      for (int e = 0; e < 7; e++)
      begin
        if (e < 6)
          flt = 6'(1 << e);
        else
          i_aah_host_model.frame(FAULT_CODE_ADDR, 8'h00);
        @(posedge clock) #1;
        flt = 6'h00;
        repeat (3) @(posedge clock) #1;
        chk("alert line", {31'h0, |(codes[e] & masks[m])}, {31'h0, host_alert_line});
        rd_chk("fault code", FAULT_CODE_ADDR, codes[e]);
        chk("alert after read", 32'h0, {31'h0, host_alert_line});
      end
    end
  endtask

  task automatic t_hold;
    i_aah_host_model.frame(VOL_ADDR[IDX_HOLD], HOLD_ON);
    host_cmd_n = 1'b0;
    repeat (4) @(posedge clock) #1;
    rx_send(8'ha0);
    repeat (30) @(posedge clock) #1;
    chk("held count", 32'h0, 32'(i_aah_host_model.radio_q.size()));
    // stalled uart on release, so the first byte must stand in the slot
    i_aah_host_model.stall = 1'b1;
    host_cmd_n = 1'b1;
    repeat (10) @(posedge clock) #1;
    i_aah_host_model.stall = 1'b0;
    rx_expect("released bytes", 8'ha0);
    packet_receive_option = 1'b1;
    host_cmd_n = 1'b0;
    rx_send(8'hb0);
    rx_expect("override bytes", 8'hb0);
    packet_receive_option = 1'b0;
    host_cmd_n = 1'b1;
    i_aah_host_model.frame(VOL_ADDR[IDX_HOLD], 8'h00);
    host_cmd_n = 1'b0;
    rx_send(8'hc0);
    rx_expect("direct bytes", 8'hc0);
    host_cmd_n = 1'b1;
  endtask

  // held buffer filled one past its depth
  task automatic t_overflow;
    i_aah_host_model.frame(VOL_ADDR[IDX_HOLD], HOLD_ON);
    i_aah_host_model.frame(VOL_ADDR[IDX_ALERT], 8'h08);
    host_cmd_n = 1'b0;
    repeat (4) @(posedge clock) #1;
    for (int i = 0; i <= RXBUF_DEPTH; i++)
    begin
      rx_byte  = 8'(i);
      rx_valid = 1'b1;
      @(posedge clock) #1;
    end
    rx_valid = 1'b0;
    repeat (2) @(posedge clock) #1;
    chk("overflow alert", 32'h1, {31'h0, host_alert_line});
    rd_chk("overflow code", FAULT_CODE_ADDR, FAULT_CODES[EV_RADIO_OVF]);
    i_aah_host_model.radio_q.delete();
    host_cmd_n = 1'b1;
    repeat (250) @(posedge clock) #1;
    chk("held bytes", 32'(RXBUF_DEPTH), 32'(i_aah_host_model.radio_q.size()));
    chk("last held byte", 32'h3f, {24'h0, i_aah_host_model.radio_q[RXBUF_DEPTH-1]});
  endtask

  task automatic t_stored;
    i_aah_host_model.frame(NV_ADDR[IDX_ALERT], 8'h5a);
    rd_chk("stored mask", NV_ADDR[IDX_ALERT], 8'h5a);
    do_reset;
    // stored copies clear with the bank, so the load brings their reset value
    rd_chk("loaded mask", VOL_ADDR[IDX_ALERT], NV_RESET[IDX_ALERT]);
  endtask

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    host_cmd_n = 1'b1;
    packet_receive_option = 1'b0;
    flt = 6'h00;
    do_reset;
    t_defaults;
    t_bytes;
    t_alert;
    t_hold;
    t_overflow;
    t_stored;
    print_verdict;
  end

  // whole run needs under two thousand cycles
  initial
  begin
    #1600000;
    fails++;
    print_verdict;
  end
endmodule
